//--- rtl/pmf_defs.svh
// Register offsets, reset values, field masks and protocol constants of the fault flag block
`ifndef PMF_DEFS_SVH
`define PMF_DEFS_SVH

// Register pointer values
`define PMF_THERM_IE_ADDR    8'h05
`define PMF_RAIL_IE_ADDR     8'h06
`define PMF_THERM_STAT_ADDR  8'h07
`define PMF_RAIL_STAT_ADDR   8'h08

// Reset values
`define PMF_THERM_IE_RST     8'h7F
`define PMF_RAIL_IE_RST      8'hFF
`define PMF_STAT_RST         8'h00
`define PMF_PTR_RST          8'h00

// Writable bits of each enable register
`define PMF_THERM_IE_WMASK   8'h7C
`define PMF_RAIL_IE_WMASK    8'hFF

// Bits that latch an event and hold it until read
`define PMF_THERM_STICKY     8'h83
`define PMF_RAIL_STICKY      8'h01

// Answer for an unmapped pointer
`define PMF_UNMAPPED_DATA    8'h00

// Serial engine
`define PMF_BITS_PER_BYTE    4'h8
`define PMF_BIT_CNT_RST      4'h0
`define PMF_BIT_CNT_ONE      4'h1
`define PMF_PTR_ONE          8'h01
`define PMF_BYTE_RST         8'h00
`define PMF_DEV_ADDR_DFLT    7'h20

`endif

//--- rtl/pmf_fault_irq.sv
// Fault and event flags, interrupt enables and open-drain interrupt pin behind a serial slave
`timescale 1ns/10ps
`include "pmf_defs.svh"

// Notes on behaviour
// - Rail enable register is eight read-write bits, boost enable on top, reset all ones.
// - Enabled pending event pulls interrupt pin low; disabled event leaves pin released.
// - Rail enable bit zero gates conversion done, bit two gates backplane fault.
// - Thermal status top bit latches a panel temperature step event; resets to zero.
// - Thermal status bit six reads one while in over-temperature shutdown.
// - Thermal status bit five reads one while near over-temperature shutdown.
// - Thermal status bit four reads one while thermistor is at or above hot limit.
// - Thermal status bit three reads one while thermistor is at or below cold limit.
// - Thermal status bit two reads one while input supply is under lockout level.
// - Thermal status bit one latches kick-back measurement done; resets to zero.
// - Thermal status bit zero latches storage programming done; resets to zero.
// - Rail status top bit reports boost converter under-voltage.
// - Rail status bit six reports positive gate pump under-voltage.
// - Rail status bit five reports inverting converter under-voltage.
// - Rail status bit four reports positive source regulator under-voltage.
// - Rail status bit three reports negative gate pump under-voltage.
// - Rail status bit two reports backplane voltage outside its range.
// - Rail status bit one reports negative source regulator under-voltage.
// - Rail status bit zero latches temperature conversion complete.
// - Thermal status bits are gated to the pin by the thermal enable register.
module pmf_fault_irq
  import pmf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `PMF_DEV_ADDR_DFLT
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Serial control pins, open drain data
  input  wire logic scl,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  // Thermal and supply events
  input  wire logic panelTempDeltaEvt,
  input  wire logic overtempShutdownIn,
  input  wire logic overtempWarnIn,
  input  wire logic thermistorHotIn,
  input  wire logic thermistorColdIn,
  input  wire logic inputUndervoltIn,
  input  wire logic kickbackDoneEvt,
  input  wire logic nvmProgramDoneEvt,
  // Rail events
  input  wire logic posBoostUvIn,
  input  wire logic posGatePumpUvIn,
  input  wire logic invConverterUvIn,
  input  wire logic posSourceUvIn,
  input  wire logic negGatePumpUvIn,
  input  wire logic backplaneFaultIn,
  input  wire logic negSourceUvIn,
  input  wire logic tempConvDoneEvt,
  // Interrupt pin, active low
  output logic      irqOutN
);

  // Pin history for edge and condition detection
  logic           sclPrev_r;
  logic           sdaPrev_r;
  logic           sclPrev_nxt;
  logic           sdaPrev_nxt;
  logic           sclRise;
  logic           sclFall;
  logic           startDet;
  logic           stopDet;

  // Serial engine state
  pmf_ser_state_t state_r;
  pmf_ser_state_t state_nxt;
  logic [3:0]     bitCnt_r;
  logic [3:0]     bitCnt_nxt;
  logic [7:0]     shift_r;
  logic [7:0]     shift_nxt;
  logic [7:0]     ptr_r;
  logic [7:0]     ptr_nxt;
  logic           sdaOe_r;
  logic           sdaOe_nxt;
  logic           hostNack_r;
  logic           hostNack_nxt;
  logic           wrStb;
  logic           rdStb;
  logic [7:0]     rdData;

  // Enable registers and flags
  logic [7:0]     thermIe_r;
  logic [7:0]     thermIe_nxt;
  logic [7:0]     railIe_r;
  logic [7:0]     railIe_nxt;
  logic [7:0]     thermSrc;
  logic [7:0]     railSrc;
  logic [7:0]     thermFlags;
  logic [7:0]     railFlags;
  logic           thermClr;
  logic           railClr;
  logic           irqOutN_r;
  logic           irqOutN_nxt;

  // Pin history; inputs already arrive in the clock domain
  always_comb begin
    sclPrev_nxt = scl;
    sdaPrev_nxt = sdaIn;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclPrev_nxt;
      sdaPrev_r <= sdaPrev_nxt;
    end
  end

  // Bus conditions; start and stop are data edges while the clock is high
  assign sclRise  = scl & ~sclPrev_r;
  assign sclFall  = ~scl & sclPrev_r;
  assign startDet = scl & sclPrev_r & sdaPrev_r & ~sdaIn;
  assign stopDet  = scl & sclPrev_r & ~sdaPrev_r & sdaIn;

  // Register read mux; unmapped pointers answer zero
  always_comb begin
    case (ptr_r)
      `PMF_THERM_IE_ADDR:   rdData = thermIe_r;
      `PMF_RAIL_IE_ADDR:    rdData = railIe_r;
      `PMF_THERM_STAT_ADDR: rdData = thermFlags;
      `PMF_RAIL_STAT_ADDR:  rdData = railFlags;
      default:              rdData = `PMF_UNMAPPED_DATA;
    endcase
  end

  // Serial engine: address, pointer, write bytes, read bytes with auto increment
  always_comb begin
    state_nxt    = state_r;
    bitCnt_nxt   = bitCnt_r;
    shift_nxt    = shift_r;
    ptr_nxt      = ptr_r;
    sdaOe_nxt    = sdaOe_r;
    hostNack_nxt = hostNack_r;
    wrStb        = 1'b0;
    rdStb        = 1'b0;
    if (stopDet) begin
      state_nxt = PMF_IDLE;
      sdaOe_nxt = 1'b0;
    end else if (startDet) begin
      // Repeated start keeps the pointer so a read can follow a pointer write
      state_nxt  = PMF_ADDR;
      bitCnt_nxt = `PMF_BIT_CNT_RST;
      sdaOe_nxt  = 1'b0;
    end else begin
      case (state_r)
        PMF_IDLE: begin
          sdaOe_nxt = 1'b0;
        end
        PMF_ADDR, PMF_PTR, PMF_WDATA: begin
          if (sclRise) begin
            shift_nxt  = {shift_r[6:0], sdaIn};
            bitCnt_nxt = bitCnt_r + `PMF_BIT_CNT_ONE;
          end else if (sclFall && bitCnt_r == `PMF_BITS_PER_BYTE) begin
            bitCnt_nxt = `PMF_BIT_CNT_RST;
            sdaOe_nxt  = 1'b1;
            if (state_r == PMF_ADDR) begin
              // A foreign address is not acknowledged and the engine goes quiet
              if (shift_r[7:1] == DEV_ADDR) begin
                state_nxt = PMF_ADDR_ACK;
              end else begin
                state_nxt = PMF_IDLE;
                sdaOe_nxt = 1'b0;
              end
            end else if (state_r == PMF_PTR) begin
              ptr_nxt   = shift_r;
              state_nxt = PMF_PTR_ACK;
            end else begin
              wrStb     = 1'b1;
              state_nxt = PMF_WDATA_ACK;
            end
          end
        end
        PMF_ADDR_ACK: begin
          if (sclFall) begin
            bitCnt_nxt = `PMF_BIT_CNT_RST;
            if (shift_r[0]) begin
              rdStb     = 1'b1;
              shift_nxt = rdData;
              sdaOe_nxt = ~rdData[7];
              state_nxt = PMF_RDATA;
            end else begin
              sdaOe_nxt = 1'b0;
              state_nxt = PMF_PTR;
            end
          end
        end
        PMF_PTR_ACK: begin
          if (sclFall) begin
            sdaOe_nxt = 1'b0;
            state_nxt = PMF_WDATA;
          end
        end
        PMF_WDATA_ACK: begin
          if (sclFall) begin
            sdaOe_nxt = 1'b0;
            ptr_nxt   = ptr_r + `PMF_PTR_ONE;
            state_nxt = PMF_WDATA;
          end
        end
        PMF_RDATA: begin
          if (sclRise) begin
            bitCnt_nxt = bitCnt_r + `PMF_BIT_CNT_ONE;
          end else if (sclFall) begin
            if (bitCnt_r == `PMF_BITS_PER_BYTE) begin
              // Release the line so the host can answer
              sdaOe_nxt = 1'b0;
              ptr_nxt   = ptr_r + `PMF_PTR_ONE;
              state_nxt = PMF_RDATA_ACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              sdaOe_nxt = ~shift_r[6];
            end
          end
        end
        PMF_RDATA_ACK: begin
          if (sclRise) begin
            hostNack_nxt = sdaIn;
          end else if (sclFall) begin
            bitCnt_nxt = `PMF_BIT_CNT_RST;
            if (hostNack_r) begin
              state_nxt = PMF_IDLE;
            end else begin
              rdStb     = 1'b1;
              shift_nxt = rdData;
              sdaOe_nxt = ~rdData[7];
              state_nxt = PMF_RDATA;
            end
          end
        end
        default: begin
          state_nxt = PMF_IDLE;
          sdaOe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r    <= PMF_IDLE;
      bitCnt_r   <= `PMF_BIT_CNT_RST;
      shift_r    <= `PMF_BYTE_RST;
      ptr_r      <= `PMF_PTR_RST;
      sdaOe_r    <= 1'b0;
      hostNack_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      bitCnt_r   <= bitCnt_nxt;
      shift_r    <= shift_nxt;
      ptr_r      <= ptr_nxt;
      sdaOe_r    <= sdaOe_nxt;
      hostNack_r <= hostNack_nxt;
    end
  end

  // Open drain: the data level is always low, the enable carries the bit
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_r;

  // Enable register writes; read-only enable bits keep their reset value
  always_comb begin
    thermIe_nxt = thermIe_r;
    railIe_nxt  = railIe_r;
    if (wrStb && ptr_r == `PMF_THERM_IE_ADDR) begin
      thermIe_nxt = (thermIe_r & ~`PMF_THERM_IE_WMASK) | (shift_r & `PMF_THERM_IE_WMASK);
    end
    if (wrStb && ptr_r == `PMF_RAIL_IE_ADDR) begin
      railIe_nxt = (railIe_r & ~`PMF_RAIL_IE_WMASK) | (shift_r & `PMF_RAIL_IE_WMASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      thermIe_r <= `PMF_THERM_IE_RST;
      railIe_r  <= `PMF_RAIL_IE_RST;
    end else begin
      thermIe_r <= thermIe_nxt;
      railIe_r  <= railIe_nxt;
    end
  end

  // Thermal status sources, top to bottom
  assign thermSrc[7] = panelTempDeltaEvt;
  assign thermSrc[6] = overtempShutdownIn;
  assign thermSrc[5] = overtempWarnIn;
  assign thermSrc[4] = thermistorHotIn;
  assign thermSrc[3] = thermistorColdIn;
  assign thermSrc[2] = inputUndervoltIn;
  assign thermSrc[1] = kickbackDoneEvt;
  assign thermSrc[0] = nvmProgramDoneEvt;

  // Rail status sources, top to bottom
  assign railSrc[7] = posBoostUvIn;
  assign railSrc[6] = posGatePumpUvIn;
  assign railSrc[5] = invConverterUvIn;
  assign railSrc[4] = posSourceUvIn;
  assign railSrc[3] = negGatePumpUvIn;
  assign railSrc[2] = backplaneFaultIn;
  assign railSrc[1] = negSourceUvIn;
  assign railSrc[0] = tempConvDoneEvt;

  // Reading a status register is what clears its sticky bits
  assign thermClr = rdStb && ptr_r == `PMF_THERM_STAT_ADDR;
  assign railClr  = rdStb && ptr_r == `PMF_RAIL_STAT_ADDR;

  pmf_status_reg #(
    .WIDTH  (8),
    .STICKY (`PMF_THERM_STICKY)
  ) u_therm_stat (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .srcIn   (thermSrc),
    .clrStb  (thermClr),
    .flags   (thermFlags)
  );

  pmf_status_reg #(
    .WIDTH  (8),
    .STICKY (`PMF_RAIL_STICKY)
  ) u_rail_stat (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .srcIn   (railSrc),
    .clrStb  (railClr),
    .flags   (railFlags)
  );

  // Pin is low while any enabled flag is pending, bit for bit per register
  always_comb begin
    irqOutN_nxt = ~(|(thermFlags & thermIe_r) | |(railFlags & railIe_r));
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqOutN_r <= 1'b1;
    end else begin
      irqOutN_r <= irqOutN_nxt;
    end
  end

  assign irqOutN = irqOutN_r;

endmodule

//--- rtl/pmf_pkg.sv
// Types shared by the fault flag block
package pmf_pkg;

  // Serial control engine states
  typedef enum logic [3:0] {
    PMF_IDLE,
    PMF_ADDR,
    PMF_ADDR_ACK,
    PMF_PTR,
    PMF_PTR_ACK,
    PMF_WDATA,
    PMF_WDATA_ACK,
    PMF_RDATA,
    PMF_RDATA_ACK
  } pmf_ser_state_t;

endpackage

//--- rtl/pmf_status_reg.sv
// One status register: level bits follow their source, sticky bits latch until read
`timescale 1ns/10ps
`include "pmf_defs.svh"

module pmf_status_reg
  import pmf_pkg::*;
#(
  parameter int unsigned        WIDTH  = 8,
  parameter logic [WIDTH-1:0]   STICKY = `PMF_RAIL_STICKY
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Sources and clear
  input  wire logic [WIDTH-1:0] srcIn,
  input  wire logic             clrStb,
  // Register contents
  output logic [WIDTH-1:0]      flags
);

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // Set beats clear so an event landing on the read is kept for the next read
  always_comb begin
    flags_nxt = (STICKY & ((flags_r & ~{WIDTH{clrStb}}) | srcIn)) | (~STICKY & srcIn);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_r <= `PMF_STAT_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule

//--- tb/pmf_fault_irq_sva.sv
// Port-level checks of the fault flag block
`timescale 1ns/10ps
module pmf_fault_irq_sva (
  // Clock, reset, serial
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Events
  input wire logic panelTempDeltaEvt,
  input wire logic overtempShutdownIn,
  input wire logic overtempWarnIn,
  input wire logic thermistorHotIn,
  input wire logic thermistorColdIn,
  input wire logic inputUndervoltIn,
  input wire logic kickbackDoneEvt,
  input wire logic nvmProgramDoneEvt,
  input wire logic posBoostUvIn,
  input wire logic posGatePumpUvIn,
  input wire logic invConverterUvIn,
  input wire logic posSourceUvIn,
  input wire logic negGatePumpUvIn,
  input wire logic backplaneFaultIn,
  input wire logic negSourceUvIn,
  input wire logic tempConvDoneEvt,
  // Interrupt
  input wire logic irqOutN
);
  logic [7:0] postRst_r, postRst_nxt;
  logic       seen_r, seen_nxt, stk_r, stk_nxt;
  logic       railLvl, thermLvl, lvlAny, stkIn, win;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Input groups; the window is too short for any register write to land
  assign railLvl  = posBoostUvIn | posGatePumpUvIn | invConverterUvIn | posSourceUvIn
                  | negGatePumpUvIn | backplaneFaultIn | negSourceUvIn;
  assign thermLvl = overtempShutdownIn | overtempWarnIn | thermistorHotIn
                  | thermistorColdIn | inputUndervoltIn;
  assign lvlAny   = railLvl | thermLvl;
  assign stkIn    = kickbackDoneEvt | nvmProgramDoneEvt | tempConvDoneEvt;
  assign win      = (postRst_r >= 8'h02) && (postRst_r < 8'h50);

  // Cycles since reset and events seen since then
  always_comb begin
    postRst_nxt = (postRst_r == 8'hFF) ? postRst_r : postRst_r + 8'h01;
    stk_nxt     = stk_r | stkIn;
    seen_nxt    = seen_r | stkIn | lvlAny;
    if (!rst_n) begin
      postRst_nxt = 8'h00;
      stk_nxt     = 1'b0;
      seen_nxt    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    postRst_r <= postRst_nxt;
    stk_r     <= stk_nxt;
    seen_r    <= seen_nxt;
  end

  chk_reset_idle: assert property ($rose(rst_n) |-> irqOutN && !sdaOe)
    else $error("pin or data driver active after reset");
  chk_ack_edge: assert property ($changed(sdaOe) |-> !$past(scl) && $past(scl, 2))
    else $error("data driver moved outside clock low phase");
  chk_od_low: assert property (sdaOut == 1'b0)
    else $error("open drain value not low");
  chk_rail_level: assert property (win && railLvl |=> ##1 !irqOutN)
    else $error("rail level did not pull interrupt");
  chk_therm_level: assert property (win && thermLvl |-> ##2 !irqOutN)
    else $error("thermal level did not pull interrupt");
  chk_sticky_hold: assert property (win && stkIn |-> ##2 !irqOutN [*6])
    else $error("latched event did not hold interrupt");
  chk_no_spurious: assert property (win && !seen_r |-> irqOutN)
    else $error("interrupt without enabled cause");
  chk_irq_release: assert property (win && !stk_r && !$past(lvlAny) |=> irqOutN)
    else $error("interrupt held with nothing pending");

  cover property ($rose(sdaOe));
  cover property (win && stkIn);
  cover property ($rose(irqOutN));
endmodule

bind pmf_fault_irq pmf_fault_irq_sva pmf_fault_irq_sva_inst (.ref_clk, .rst_n, .scl,
  .sdaOut, .sdaOe, .panelTempDeltaEvt, .overtempShutdownIn, .overtempWarnIn,
  .thermistorHotIn, .thermistorColdIn, .inputUndervoltIn, .kickbackDoneEvt,
  .nvmProgramDoneEvt, .posBoostUvIn, .posGatePumpUvIn, .invConverterUvIn, .posSourceUvIn,
  .negGatePumpUvIn, .backplaneFaultIn, .negSourceUvIn, .tempConvDoneEvt, .irqOutN);

//--- tb/pmf_fault_irq_tb.sv
// Testbench: register access, flag mapping and interrupt pin
`timescale 1ns/10ps
module pmf_fault_irq_tb;
  localparam logic [6:0]  DEV = 7'h20; // Arbitrary device address
  localparam logic [15:0] STK = 16'h8301; // Latching events: thermal 7,1,0 and rail 0
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [15:0] ev      = 16'h0000;
  logic        scl, sdaLow, sdaOut, sdaOe, irqOutN, ok;
  wire         sdaWire;
  logic [15:0] q, r;
  logic [7:0]  tw, rw;
  int          bad_count = 0;
  int          n_checks  = 0;

  always #2.5 ref_clk = ~ref_clk;
  // Pull-up wire; either side may pull low
  assign sdaWire = !sdaLow && !(sdaOe && !sdaOut);

  pmf_fault_irq #(.DEV_ADDR(DEV)) pmf_fault_irq_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .panelTempDeltaEvt(ev[15]), .overtempShutdownIn(ev[14]), .overtempWarnIn(ev[13]),
    .thermistorHotIn(ev[12]), .thermistorColdIn(ev[11]), .inputUndervoltIn(ev[10]),
    .kickbackDoneEvt(ev[9]), .nvmProgramDoneEvt(ev[8]), .posBoostUvIn(ev[7]),
    .posGatePumpUvIn(ev[6]), .invConverterUvIn(ev[5]), .posSourceUvIn(ev[4]),
    .negGatePumpUvIn(ev[3]), .backplaneFaultIn(ev[2]), .negSourceUvIn(ev[1]),
    .tempConvDoneEvt(ev[0]), .irqOutN(irqOutN));

  pmf_host_model #(.DEV(DEV)) pmf_host_model_inst (.ref_clk(ref_clk), .scl(scl),
    .sdaLow(sdaLow), .sdaWire(sdaWire));

  // Thermal enable: only bits 6..2 take writes, 1..0 stay set
  function automatic logic [7:0] expIe(input logic [7:0] w);
    return (w & 8'h7C) | 8'h03;
  endfunction

  function automatic logic [15:0] expIrq(input logic [15:0] f, input logic [7:0] t, rr);
    return {15'h0000, !(|((f[15:8] & t) | (f[7:0] & rr)))};
  endfunction

  task automatic chk(input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end

  initial begin
    void'($urandom(32'h8a00_157d));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Early events with reset enables; step event alone never pulls the pin
    repeat (3) @(posedge ref_clk);
    ev <= 16'h0080;
    repeat (3) @(posedge ref_clk);
    ev <= 16'h0400;
    repeat (3) @(posedge ref_clk);
    ev <= 16'h8200;
    @(posedge ref_clk);
    ev <= 16'h0000;
    repeat (20) @(posedge ref_clk);
    chk({15'h0000, irqOutN}, 16'h0000);
    pmf_host_model_inst.readPair(8'h05, q);
    chk(q, 16'h7FFF);
    pmf_host_model_inst.readPair(8'h07, q);
    chk(q, 16'h8200);
    chk({15'h0000, irqOutN}, 16'h0001);
    $display("test reset window done");
    // Wrong address refused; unmapped and read-only places
    pmf_host_model_inst.writeReg(7'h21, 8'h06, 8'h00, ok);
    chk({15'h0000, ok}, 16'h0000);
    pmf_host_model_inst.writeReg(DEV, 8'h08, 8'hFF, ok);
    chk({15'h0000, ok}, 16'h0001);
    pmf_host_model_inst.writeReg(DEV, 8'h30, 8'hAA, ok);
    pmf_host_model_inst.readPair(8'h30, q);
    chk(q, 16'h0000);
    // Foreign address and read-only writes must not have landed
    pmf_host_model_inst.readPair(8'h05, q);
    chk(q, 16'h7FFF);
    pmf_host_model_inst.readPair(8'h07, q);
    chk(q, 16'h0000);
    $display("test refusals done");
    // Random flags and enables, corners first
    for (int i = 0; i < 12; i++) begin
      r  = $urandom;
      tw = $urandom;
      rw = $urandom;
      if (i == 0) begin
        r  = 16'hFFFF;
        tw = 8'hFF;
        rw = 8'h00;
      end
      if (i == 1) begin
        r  = 16'h7CFE;
        tw = 8'h00;
        rw = 8'h01;
      end
      pmf_host_model_inst.writeReg(DEV, 8'h05, tw, ok);
      pmf_host_model_inst.writeReg(DEV, 8'h06, rw, ok);
      pmf_host_model_inst.readPair(8'h05, q);
      chk(q, {expIe(tw), rw});
      @(posedge ref_clk);
      ev <= r;
      @(posedge ref_clk);
      ev <= r & ~STK;
      repeat (3) @(posedge ref_clk);
      chk({15'h0000, irqOutN}, expIrq(r, expIe(tw), rw));
      pmf_host_model_inst.readPair(8'h07, q);
      chk(q, r);
      repeat (3) @(posedge ref_clk);
      chk({15'h0000, irqOutN}, expIrq(r & ~STK, expIe(tw), rw));
    end
    $display("test random flags done");
    // Second reset in mid-run restores enables
    @(posedge ref_clk);
    ev    <= 16'h0000;
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    pmf_host_model_inst.readPair(8'h05, q);
    chk(q, 16'h7FFF);
    $display("test second reset done");
    conclude();
  end
endmodule

//--- tb/pmf_host_model.sv
// Serial host model: drives clock, pulls data low, reads back over a pull-up
`timescale 1ns/10ps
module pmf_host_model #(
  parameter logic [6:0] DEV = 7'h20
) (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  output logic     scl,
  output logic     sdaLow,
  input wire logic sdaWire
);
  // Idle bus: clock stands high, data released
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Data moves only while the clock is low; sampled late in the high phase
  task automatic bitX(input logic b, output logic r);
    sdaLow <= !b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    r = sdaWire;
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic start();
    @(posedge ref_clk);
    sdaLow <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop();
    sdaLow <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b0;
    tick(4);
  endtask

  // Eight bits first to last, then the acknowledge bit
  task automatic byteX(input logic [7:0] d, input logic hAck, output logic [7:0] q,
                       output logic nak);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitX(d[i], b);
      q[i] = b;
    end
    bitX(!hAck, nak);
  endtask

  task automatic writeReg(input logic [6:0] dev, input logic [7:0] ptr, d, output logic ok);
    logic [7:0] q;
    logic       n0, n1, n2;
    start();
    byteX({dev, 1'b0}, 1'b0, q, n0);
    byteX(ptr, 1'b0, q, n1);
    byteX(d, 1'b0, q, n2);
    stop();
    ok = !(n0 | n1 | n2);
  endtask

  // Two bytes from ptr and ptr+1; the second is refused to end the read
  task automatic readPair(input logic [7:0] ptr, output logic [15:0] q);
    logic [7:0] hi, lo, x;
    logic       n;
    start();
    byteX({DEV, 1'b0}, 1'b0, x, n);
    byteX(ptr, 1'b0, x, n);
    start();
    byteX({DEV, 1'b1}, 1'b0, x, n);
    byteX(8'hFF, 1'b1, hi, n);
    byteX(8'hFF, 1'b0, lo, n);
    stop();
    q = {hi, lo};
  endtask
endmodule
